// File: deb_bank.sv
`timescale 1ns/1ps
`default_nettype none
// Behaviour
// (R1) read-only type word, preset 00060192h
// (R2) bits 23:16 give motor type
// (R3) low half gives profile 0192h
// (R4) summary bit follows live error
// (R5) fixed summary bit map, bit 6 zero
// (R6) each error records 32-bit history code
// (R7) newest at entry 1, oldest dropped
// (R8) subindex 0 reports error count
// (R9) empty stack entry read aborts 08000024h
// (R10) writing zero restarts error counting
// (R11) entry: number, class, code fields
// (R12) count saturates at eight
module deb_bank
	import deb_pkg::*;
#(
	parameter logic [7:0] MOTOR_TYPE = MOTOR_BOTH  // supported motor type
) (
	input  wire logic        clk_sys,            // system clock
	input  wire logic        reset_n,            // async reset, low
	input  wire logic        general_fault_flag, // general error live
	input  wire logic        current_fault_flag, // current error live
	input  wire logic        voltage_fault_flag, // voltage error live
	input  wire logic        temp_fault_flag,    // temperature error live
	input  wire logic        link_fault_flag,    // communication error live
	input  wire logic        profile_fault_flag, // profile error live
	input  wire logic        unused_flag,        // reserved, ignored
	input  wire logic        vendor_fault_flag,  // vendor error live
	input  wire logic        err_event,          // new error pulse
	input  wire logic [7:0]  err_number,         // cause number
	input  wire logic [15:0] err_code,           // detailed code
	input  wire logic        req_valid,          // access request pulse
	input  wire logic        req_write,          // 1 write, 0 read
	input  wire logic [15:0] req_index,          // object index
	input  wire logic [7:0]  req_subindex,       // object subindex
	input  wire logic [31:0] req_wdata,          // write data
	output logic             rsp_valid,          // answer pulse
	output logic             rsp_abort,          // answer is an abort
	output logic      [31:0] rsp_data,           // read data or abort code
	output logic      [7:0]  error_summary       // live summary byte
);
	// only three motor codes exist, refuse anything else at elaboration
	if (MOTOR_TYPE != MOTOR_BLDC && MOTOR_TYPE != MOTOR_STEPPER
		&& MOTOR_TYPE != MOTOR_BOTH) begin : g_bad_motor
		$error("motor type must be 2, 4 or 6");
	end

	logic [7:0]  summary_q;    // registered summary byte
	logic [7:0]  summary_d;    // live summary
	logic        rsp_valid_q;  // answer strobe
	logic        rsp_abort_q;  // abort flag
	logic [31:0] rsp_data_q;   // answer word
	logic [31:0] hist_word;    // selected history entry
	logic [7:0]  hist_count;   // history count
	logic [2:0]  hist_slot;    // selected slot
	logic        hist_clear;   // count restart
	logic        entry_sel;    // subindex in 1..8
	logic [31:0] dev_type;     // device-type word

	// (R2) motor type in bits 23:16, (R3) profile in low half
	assign dev_type = {DEVICE_TYPE_PAD, MOTOR_TYPE, PROFILE_DRIVE};

	// (R5) fixed bit map, reserved bit held at zero
	always_comb begin
		summary_d              = ZERO_BYTE;
		summary_d[BIT_GENERAL] = general_fault_flag;
		summary_d[BIT_CURRENT] = current_fault_flag;
		summary_d[BIT_VOLTAGE] = voltage_fault_flag;
		summary_d[BIT_TEMP]    = temp_fault_flag;
		summary_d[BIT_LINK]    = link_fault_flag;
		summary_d[BIT_PROFILE] = profile_fault_flag;
		summary_d[BIT_UNUSED]  = 1'b0;  // unused_flag deliberately dropped
		summary_d[BIT_VENDOR]  = vendor_fault_flag;
	end

	// (R4) summary follows live errors, no clearing write
	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) summary_q <= ZERO_BYTE;
		else          summary_q <= summary_d;
	end
	assign error_summary = summary_q;

	// entries 1..8 map to slots 0..7
	assign entry_sel  = req_subindex >= SUB_FIRST_ENTRY && req_subindex <= SUB_LAST_ENTRY;
	assign hist_slot  = 3'(req_subindex - SUB_FIRST_ENTRY);
	// (R10) a zero write to subindex 0 restarts the count
	assign hist_clear = req_valid && req_write && req_index == IDX_ERROR_HISTORY
		&& req_subindex == SUB_COUNT && req_wdata == ZERO_WORD;

	// (R6) every error pushes a word, (R11) number, class, code
	deb_history #(
		.DEPTH (8)
	) u_history (
		.clk_sys   (clk_sys),
		.reset_n   (reset_n),
		.push      (err_event),
		.push_word ({err_number, summary_d, err_code}),
		.clear     (hist_clear),
		.rd_slot   (hist_slot),
		.rd_word   (hist_word),
		.count     (hist_count)
	);

	// access decoder, one answer per request one cycle later
	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			rsp_valid_q <= 1'b0;
			rsp_abort_q <= 1'b0;
			rsp_data_q  <= ZERO_WORD;
		end else begin
			rsp_valid_q <= req_valid;
			rsp_abort_q <= 1'b0;
			rsp_data_q  <= ZERO_WORD;
			if (!req_valid) begin
				rsp_valid_q <= 1'b0;
			end else if (req_index == IDX_DEVICE_TYPE && req_subindex == SUB_COUNT) begin
				// (R1) read-only, writes refused
				rsp_abort_q <= req_write;
				rsp_data_q  <= req_write ? ABORT_READ_ONLY : dev_type;
			end else if (req_index == IDX_ERROR_SUMMARY && req_subindex == SUB_COUNT) begin
				rsp_abort_q <= req_write;
				rsp_data_q  <= req_write ? ABORT_READ_ONLY : {24'h000000, summary_q};
			end else if (req_index == IDX_ERROR_HISTORY && req_subindex == SUB_COUNT) begin
				// (R8) count read; (R10) only zero may be written
				if (req_write && req_wdata != ZERO_WORD) begin
					rsp_abort_q <= 1'b1;
					rsp_data_q  <= ABORT_BAD_VALUE;
				end else if (!req_write) begin
					rsp_data_q  <= {24'h000000, hist_count};
				end
			end else if (req_index == IDX_ERROR_HISTORY && entry_sel) begin
				// (R9) empty stack refuses entry reads
				if (req_write) begin
					rsp_abort_q <= 1'b1;
					rsp_data_q  <= ABORT_READ_ONLY;
				end else if (hist_count == ZERO_BYTE) begin
					rsp_abort_q <= 1'b1;
					rsp_data_q  <= ABORT_NO_DATA;
				end else begin
					rsp_data_q  <= hist_word;
				end
			end else begin
				rsp_abort_q <= 1'b1;
				rsp_data_q  <= ABORT_NO_OBJECT;
			end
		end
	end

	assign rsp_valid = rsp_valid_q;
	assign rsp_abort = rsp_abort_q;
	assign rsp_data  = rsp_data_q;

	// checks
	sequence s_type_read;
		req_valid && !req_write && req_index == IDX_DEVICE_TYPE && req_subindex == SUB_COUNT;
	endsequence
	property p_type_word;
		@(posedge clk_sys) disable iff (!reset_n)
		s_type_read |=> rsp_valid && !rsp_abort && rsp_data == {8'h00, MOTOR_TYPE, 16'h0192};
	endproperty
	a_type_word: assert property (p_type_word) else $error("device type word wrong"); // (R1)

	property p_motor;
		@(posedge clk_sys) disable iff (!reset_n)
		s_type_read |=> rsp_data[23:16] inside {8'h02, 8'h04, 8'h06};
	endproperty
	a_motor: assert property (p_motor) else $error("motor type field invalid"); // (R2)

	property p_profile;
		@(posedge clk_sys) disable iff (!reset_n)
		s_type_read |=> rsp_data[15:0] == 16'h0192;
	endproperty
	a_profile: assert property (p_profile) else $error("profile field wrong"); // (R3)

	property p_summary_follow;
		@(posedge clk_sys) disable iff (!reset_n)
		1'b1 |=> error_summary[0] == $past(general_fault_flag) && error_summary[7] == $past(vendor_fault_flag);
	endproperty
	a_summary_follow: assert property (p_summary_follow) else $error("summary does not follow"); // (R4)

	property p_reserved;
		@(posedge clk_sys) disable iff (!reset_n)
		error_summary[6] == 1'b0;
	endproperty
	a_reserved: assert property (p_reserved) else $error("reserved summary bit set"); // (R5)

	property p_count_step;
		@(posedge clk_sys) disable iff (!reset_n)
		err_event && !hist_clear && hist_count < 8'h08 |=> hist_count == $past(hist_count) + 8'h01;
	endproperty
	a_count_step: assert property (p_count_step) else $error("count did not step"); // (R6)

	property p_newest;
		@(posedge clk_sys) disable iff (!reset_n)
		err_event ##1 (req_valid && !req_write && req_index == IDX_ERROR_HISTORY
			&& req_subindex == 8'h01 && !err_event) |=> rsp_data[15:0] == $past(err_code, 2);
	endproperty
	a_newest: assert property (p_newest) else $error("newest entry wrong"); // (R7)

	property p_count_read;
		@(posedge clk_sys) disable iff (!reset_n)
		req_valid && !req_write && req_index == IDX_ERROR_HISTORY && req_subindex == SUB_COUNT
			|=> rsp_data == {24'h0, $past(hist_count)};
	endproperty
	a_count_read: assert property (p_count_read) else $error("count read wrong"); // (R8)

	property p_empty_abort;
		@(posedge clk_sys) disable iff (!reset_n)
		req_valid && !req_write && req_index == IDX_ERROR_HISTORY && entry_sel && hist_count == 8'h00
			|=> rsp_abort && rsp_data == 32'h08000024;
	endproperty
	a_empty_abort: assert property (p_empty_abort) else $error("empty read not aborted"); // (R9)

	property p_clear;
		@(posedge clk_sys) disable iff (!reset_n)
		hist_clear && !err_event |=> hist_count == 8'h00;
	endproperty
	a_clear: assert property (p_clear) else $error("count not restarted"); // (R10)

	property p_class;
		@(posedge clk_sys) disable iff (!reset_n)
		err_event |=> u_history.stack_q[0][23:16] == $past(summary_d)
			&& u_history.stack_q[0][31:24] == $past(err_number);
	endproperty
	a_class: assert property (p_class) else $error("entry fields wrong"); // (R11)

	property p_saturate;
		@(posedge clk_sys) disable iff (!reset_n)
		hist_count <= 8'h08;
	endproperty
	a_saturate: assert property (p_saturate) else $error("count above eight"); // (R12)

	// named request shapes used below
	sequence s_summary_read;
		req_valid && !req_write && req_index == IDX_ERROR_SUMMARY && req_subindex == SUB_COUNT;
	endsequence

	sequence s_entry_read;
		req_valid && !req_write && req_index == IDX_ERROR_HISTORY && entry_sel;
	endsequence

	sequence s_count_write_bad;
		req_valid && req_write && req_index == IDX_ERROR_HISTORY && req_subindex == SUB_COUNT
			&& req_wdata != ZERO_WORD;
	endsequence

	sequence s_type_write;
		req_valid && req_write && req_index == IDX_DEVICE_TYPE && req_subindex == SUB_COUNT;
	endsequence

	// every request gets exactly one answer, one cycle later
	property p_rsp_follows;
		@(posedge clk_sys) disable iff (!reset_n)
		1'b1 |=> rsp_valid == $past(req_valid);
	endproperty
	a_rsp_follows: assert property (p_rsp_follows) else $error("answer strobe out of step"); // (R8)

	// idle cycles leave the answer lines at zero, so stale aborts never linger
	property p_rsp_idle;
		@(posedge clk_sys) disable iff (!reset_n)
		!req_valid |=> !rsp_abort && rsp_data == ZERO_WORD;
	endproperty
	a_rsp_idle: assert property (p_rsp_idle) else $error("answer lines not idle"); // (R9)

	property p_type_write;
		@(posedge clk_sys) disable iff (!reset_n)
		s_type_write |=> rsp_abort && rsp_data == ABORT_READ_ONLY;
	endproperty
	a_type_write: assert property (p_type_write) else $error("type word write not refused"); // (R1)

	// whole byte map, one cycle behind the live levels
	property p_summary_map;
		@(posedge clk_sys) disable iff (!reset_n)
		1'b1 |=> error_summary == {$past(vendor_fault_flag), 1'b0, $past(profile_fault_flag),
			$past(link_fault_flag), $past(temp_fault_flag), $past(voltage_fault_flag),
			$past(current_fault_flag), $past(general_fault_flag)};
	endproperty
	a_summary_map: assert property (p_summary_map) else $error("summary bit map wrong"); // (R5)

	property p_summary_read;
		@(posedge clk_sys) disable iff (!reset_n)
		s_summary_read |=> rsp_valid && !rsp_abort && rsp_data == {24'h000000, $past(error_summary)};
	endproperty
	a_summary_read: assert property (p_summary_read) else $error("summary read wrong"); // (R4)

	property p_entry_code;
		@(posedge clk_sys) disable iff (!reset_n)
		err_event |=> u_history.stack_q[0][15:0] == $past(err_code);
	endproperty
	a_entry_code: assert property (p_entry_code) else $error("error code not recorded"); // (R6)

	// first and last step of the shift
	property p_shift;
		@(posedge clk_sys) disable iff (!reset_n)
		err_event |=> u_history.stack_q[1] == $past(u_history.stack_q[0])
			&& u_history.stack_q[7] == $past(u_history.stack_q[6]);
	endproperty
	a_shift: assert property (p_shift) else $error("history did not shift"); // (R7)

	property p_entry_read;
		@(posedge clk_sys) disable iff (!reset_n)
		s_entry_read && hist_count != ZERO_BYTE |=> rsp_valid && !rsp_abort && rsp_data == $past(hist_word);
	endproperty
	a_entry_read: assert property (p_entry_read) else $error("filled entry read refused"); // (R9)

	property p_count_write_bad;
		@(posedge clk_sys) disable iff (!reset_n)
		s_count_write_bad |=> rsp_abort && rsp_data == ABORT_BAD_VALUE;
	endproperty
	a_count_write_bad: assert property (p_count_write_bad) else $error("nonzero count write accepted"); // (R10)

	// a clear and an error in one cycle keep the error
	property p_clear_event;
		@(posedge clk_sys) disable iff (!reset_n)
		hist_clear && err_event |=> hist_count == 8'h01;
	endproperty
	a_clear_event: assert property (p_clear_event) else $error("error lost during clear"); // (R10)

	property p_count_hold;
		@(posedge clk_sys) disable iff (!reset_n)
		err_event && !hist_clear && hist_count == 8'h08 |=> hist_count == 8'h08;
	endproperty
	a_count_hold: assert property (p_count_hold) else $error("full count moved"); // (R12)
endmodule
`default_nettype wire

// File: deb_pkg.sv
`default_nettype none
package deb_pkg;
	// object indices of the dictionary entries
	localparam logic [15:0] IDX_DEVICE_TYPE   = 16'h1000;
	localparam logic [15:0] IDX_ERROR_SUMMARY = 16'h1001;
	localparam logic [15:0] IDX_ERROR_HISTORY = 16'h1003;
	// subindex of the history count
	localparam logic [7:0]  SUB_COUNT         = 8'h00;
	localparam logic [7:0]  SUB_FIRST_ENTRY   = 8'h01;
	localparam logic [7:0]  SUB_LAST_ENTRY    = 8'h08;
	// device-type word fields
	localparam logic [7:0]  MOTOR_BLDC        = 8'h02;
	localparam logic [7:0]  MOTOR_STEPPER     = 8'h04;
	localparam logic [7:0]  MOTOR_BOTH        = 8'h06;
	localparam logic [15:0] PROFILE_DRIVE     = 16'h0192;
	localparam logic [7:0]  DEVICE_TYPE_PAD   = 8'h00;
	localparam logic [31:0] DEVICE_TYPE_RESET = 32'h00060192;
	// error summary bit positions
	localparam int BIT_GENERAL = 0;
	localparam int BIT_CURRENT = 1;
	localparam int BIT_VOLTAGE = 2;
	localparam int BIT_TEMP    = 3;
	localparam int BIT_LINK    = 4;
	localparam int BIT_PROFILE = 5;
	localparam int BIT_UNUSED  = 6;
	localparam int BIT_VENDOR  = 7;
	localparam logic [7:0] SUMMARY_LIVE_MASK = 8'hbf;
	// history entry layout
	localparam int ENTRY_NUM_LSB   = 24;
	localparam int ENTRY_CLASS_LSB = 16;
	// answers
	localparam logic [31:0] ABORT_NO_DATA   = 32'h08000024;
	localparam logic [31:0] ABORT_NO_OBJECT = 32'h06020000;
	localparam logic [31:0] ABORT_READ_ONLY = 32'h06010002;
	localparam logic [31:0] ABORT_BAD_VALUE = 32'h06090030;
	localparam logic [7:0]  ZERO_BYTE       = 8'h00;
	localparam logic [31:0] ZERO_WORD       = 32'h00000000;
endpackage
`default_nettype wire

// File: deb_history.sv
`timescale 1ns/1ps
`default_nettype none
// eight-deep shifting error stack with saturating count
module deb_history
	import deb_pkg::*;
#(
	parameter int DEPTH = 8
) (
	input  wire logic        clk_sys,    // system clock
	input  wire logic        reset_n,    // async reset, low
	input  wire logic        push,       // new error this cycle
	input  wire logic [31:0] push_word,  // entry to store
	input  wire logic        clear,      // restart counting
	input  wire logic [2:0]  rd_slot,    // slot 0 is newest
	output logic      [31:0] rd_word,    // selected entry
	output logic      [7:0]  count       // errors recorded
);
	// rd_slot is three bits, so exactly eight slots can be reached
	if (DEPTH != 8) begin : g_bad_depth
		$error("history depth must be 8");
	end

	logic [31:0] stack_q [DEPTH];  // slot 0 newest
	logic [7:0]  count_q;          // saturating count

	// (R7) shift and insert
	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			for (int i = 0; i < DEPTH; i++) stack_q[i] <= ZERO_WORD;
		end else if (push) begin
			// oldest entry falls off the end
			for (int i = DEPTH - 1; i > 0; i--) stack_q[i] <= stack_q[i - 1];
			stack_q[0] <= push_word;
		end
	end

	// (R12) count saturates at depth
	// (R10) a push in the clearing cycle counts as one, so it is not lost
	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			count_q <= ZERO_BYTE;
		end else if (clear) begin
			count_q <= push ? 8'h01 : ZERO_BYTE;
		end else if (push && count_q != 8'(DEPTH)) begin
			count_q <= count_q + 8'h01;
		end
	end

	assign rd_word = stack_q[rd_slot];
	assign count   = count_q;
endmodule
`default_nettype wire

// File: deb_master.sv
`timescale 1ns/1ps
`default_nettype none
// fieldbus master model: one request at a time, driven off the falling edge
module deb_master
	import deb_pkg::*;
(
	input  wire logic        clk_sys,      // system clock
	output logic             req_valid,    // request pulse
	output logic             req_write,    // 1 write, 0 read
	output logic      [15:0] req_index,    // object index
	output logic      [7:0]  req_subindex, // object subindex
	output logic      [31:0] req_wdata     // write data
);
	// idle lines hold junk so a stale request never looks valid
	initial begin
		req_valid = 1'b0;
		req_write = 1'b1;
		req_index = 16'hffff;
		req_subindex = 8'hff;
		req_wdata = 32'hffffffff;
	end

	task automatic access(input logic w, input logic [15:0] idx, input logic [7:0] sub, input logic [31:0] wd);
		@(negedge clk_sys);
		req_valid = 1'b1;
		req_write = w;
		req_index = idx;
		req_subindex = sub;
		req_wdata = wd;
		@(negedge clk_sys);
		req_valid = 1'b0;
		req_write = ~w;
		req_index = ~idx;
		req_subindex = ~sub;
		req_wdata = ~wd;
	endtask
endmodule
`default_nettype wire

// File: testbench.sv
`timescale 1ns/1ps
`default_nettype none
module testbench;
	import deb_pkg::*;
	logic        clk_sys = 1'b0;      // system clock
	logic        reset_n = 1'b0;      // async reset, low
	logic [7:0]  flags = 8'h00;       // live fault levels
	logic        err_event = 1'b0;    // new error pulse
	logic [7:0]  err_number = 8'h00;  // cause number
	logic [15:0] err_code = 16'h0000; // detailed code
	wire logic        req_valid, req_write, rsp_valid, rsp_abort;
	wire logic [15:0] req_index;
	wire logic [7:0]  req_subindex, error_summary;
	wire logic [31:0] req_wdata, rsp_data;
	int errors = 0;       // mismatches
	int total_checks = 0; // comparisons
	int seed = 96;        // random seed
	int n_hist = 0;       // model count
	logic [31:0] hist [8];     // model stack, 0 newest
	logic [33:0] expq [$];     // {data care, abort, data}
	logic [7:0]  sum_exp;      // summary due
	logic        sum_ok = 1'b0; // summary check armed

	always #5 clk_sys = ~clk_sys;

	deb_bank dut (.clk_sys(clk_sys), .reset_n(reset_n), .general_fault_flag(flags[0]),
		.current_fault_flag(flags[1]), .voltage_fault_flag(flags[2]), .temp_fault_flag(flags[3]),
		.link_fault_flag(flags[4]), .profile_fault_flag(flags[5]), .unused_flag(flags[6]),
		.vendor_fault_flag(flags[7]), .err_event(err_event), .err_number(err_number),
		.err_code(err_code), .req_valid(req_valid), .req_write(req_write), .req_index(req_index),
		.req_subindex(req_subindex), .req_wdata(req_wdata), .rsp_valid(rsp_valid),
		.rsp_abort(rsp_abort), .rsp_data(rsp_data), .error_summary(error_summary));

	deb_master host (.clk_sys(clk_sys), .req_valid(req_valid), .req_write(req_write),
		.req_index(req_index), .req_subindex(req_subindex), .req_wdata(req_wdata));

	task automatic finish_test;
		if (errors == 0 && total_checks > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask

	// answer compare; write acks ignore data
	task automatic cmp_rsp(input logic [33:0] e);
		total_checks++;
		if (rsp_abort !== e[32] || (e[33] && rsp_data !== e[31:0])) begin
			errors++;
			$display("unexpected at %0t: exp %h got %h", $time, e[32:0], {rsp_abort, rsp_data});
		end
	endtask

	task automatic cmp_sum;
		total_checks++;
		if (error_summary !== sum_exp) begin
			errors++;
			$display("unexpected at %0t: exp %h got %h", $time, sum_exp, error_summary);
		end
	endtask

	function automatic logic [33:0] ok(input logic [31:0] d);
		return {2'b10, d};
	endfunction

	function automatic logic [33:0] ab(input logic [31:0] c);
		return {2'b11, c};
	endfunction

	// note the expectation, then issue the request
	task automatic xfer(input logic w, input logic [15:0] idx, input logic [7:0] sub, input logic [31:0] wd,
		input logic [33:0] e);
		expq.push_back(e);
		host.access(w, idx, sub, wd);
	endtask

	// one error per call; caller lowers the pulse after a burst
	task automatic ev;
		logic [31:0] w;
		@(negedge clk_sys);
		flags = 8'($random(seed));
		err_number = 8'($random(seed));
		err_code = 16'($random(seed));
		err_event = 1'b1;
		w = {err_number, flags & SUMMARY_LIVE_MASK, err_code};
		for (int i = 7; i > 0; i--)
			hist[i] = hist[i-1];
		hist[0] = w;
		if (n_hist < 8)
			n_hist++;
	endtask

	task automatic check_hist;
		xfer(1'b0, IDX_ERROR_HISTORY, 8'h00, 32'h0, ok({24'h0, 8'(n_hist)})); // count
		for (int i = 1; i <= 8; i++)
			xfer(1'b0, IDX_ERROR_HISTORY, 8'(i), 32'h0, (n_hist == 0) ? ab(ABORT_NO_DATA) : ok(hist[i-1]));
	endtask

	// summary lags the live flags by one edge
	always @(posedge clk_sys) begin
		sum_exp <= flags & SUMMARY_LIVE_MASK;
		sum_ok <= reset_n;
	end

	// answer and summary watcher
	always @(negedge clk_sys) begin
		if (sum_ok && reset_n)
			cmp_sum(); // live summary
		if (rsp_valid === 1'b1) begin
			if (expq.size() == 0) begin
				errors++;
				$display("unexpected at %0t: exp %h got %h", $time, 1'b0, rsp_valid);
			end else
				cmp_rsp(expq.pop_front());
		end
	end

	// watchdog, far beyond the run
	initial begin
		#100000;
		errors++;
		finish_test();
	end

	initial begin
		for (int i = 0; i < 8; i++)
			hist[i] = 32'h0;
		repeat (20) @(negedge clk_sys);
		reset_n = 1'b1;
		xfer(1'b0, IDX_DEVICE_TYPE, 8'h00, 32'h0, ok({8'h00, 8'h06, 16'h0192})); // type word
		xfer(1'b1, IDX_DEVICE_TYPE, 8'h00, $random(seed), ab(ABORT_READ_ONLY)); // write refused
		xfer(1'b1, IDX_ERROR_SUMMARY, 8'h00, 32'h1, ab(ABORT_READ_ONLY)); // write refused
		check_hist();
		repeat (30) begin
			@(negedge clk_sys);
			flags = 8'($random(seed));
		end
		xfer(1'b0, IDX_ERROR_SUMMARY, 8'h00, 32'h0, ok({24'h0, flags & SUMMARY_LIVE_MASK})); // read
		repeat (10) ev();
		@(negedge clk_sys);
		err_event = 1'b0;
		check_hist();
		xfer(1'b1, IDX_ERROR_HISTORY, 8'h03, 32'h0, ab(ABORT_READ_ONLY)); // entries read-only
		xfer(1'b1, IDX_ERROR_HISTORY, 8'h00, 32'h5, ab(ABORT_BAD_VALUE)); // nonzero refused
		xfer(1'b1, IDX_ERROR_HISTORY, 8'h00, 32'h0, 34'h0); // clear
		n_hist = 0;
		check_hist();
		repeat (2) ev();
		// newest entry read in the cycle right after the error
		fork
			begin
				@(negedge clk_sys);
				err_event = 1'b0;
			end
			xfer(1'b0, IDX_ERROR_HISTORY, 8'h01, 32'h0, ok(hist[0])); // newest at once
		join
		check_hist();
		// clear and a new error in one cycle: the error is kept
		fork
			ev();
			xfer(1'b1, IDX_ERROR_HISTORY, 8'h00, 32'h0, 34'h0); // clear with event
		join
		err_event = 1'b0;
		n_hist = 1;
		check_hist();
		xfer(1'b0, 16'h2000, 8'h00, 32'h0, ab(ABORT_NO_OBJECT));
		xfer(1'b0, IDX_ERROR_HISTORY, 8'h09, 32'h0, ab(ABORT_NO_OBJECT));
		// second reset mid-run returns presets
		@(negedge clk_sys);
		reset_n = 1'b0;
		n_hist = 0;
		repeat (3) @(negedge clk_sys);
		reset_n = 1'b1;
		check_hist();
		xfer(1'b0, IDX_DEVICE_TYPE, 8'h00, 32'h0, ok(32'h00060192)); // preset again
		repeat (3) @(negedge clk_sys);
		if (expq.size() != 0)
			errors++;
		finish_test();
	end
endmodule
`default_nettype wire
